// [verilog/qeo_defs.svh]
/*
  Constants for the quadrature encoder output block: widths, resolution
  code limits, reset values and the angle-sample timing.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef QEO_DEFS_SVH
`define QEO_DEFS_SVH

`define QEO_ANGLE_W      14
`define QEO_POS_W        13
`define QEO_CODE_MIN     4'h3
`define QEO_CODE_MAX     4'hE
`define QEO_CODE_TOP     4'hE
`define QEO_SHIFT_BASE   4'h2
`define QEO_POS_STEP     13'h0001
`define QEO_POS_RST      13'h0000
`define QEO_QUAD_UNIT    13'h0004
`define QEO_SLEW_W       8
`define QEO_SLEW_RST     8'h00
`define QEO_CLK_NS       10
`define QEO_SAMPLE_NS    1000
`define QEO_SAMPLE_CYC   (`QEO_SAMPLE_NS / `QEO_CLK_NS)

`endif

// [verilog/qeo_pkg.sv]
/*
  Types shared by the quadrature encoder output block.
  Assumes qeo_defs.svh is on the include path.
*/
`include "qeo_defs.svh"

package qeo_pkg;

  // Quadrature states, value is the {A,B} pair
  typedef enum logic [1:0] {
    QEO_Q1 = 2'h0,
    QEO_Q2 = 2'h1,
    QEO_Q3 = 2'h3,
    QEO_Q4 = 2'h2
  } qeo_quad_e;

  typedef struct packed {
    logic a;
    logic b;
    logic i;
  } qeo_abi_s;

  typedef struct packed {
    logic                      valid;
    logic [`QEO_ANGLE_W-1:0]   angle;
  } qeo_sample_s;

endpackage : qeo_pkg

// [verilog/qeo_slew_timer.sv]
/*
  Down-counter of core clock cycles that spaces output state changes.
  Assumes load is pulsed by the owner each time it changes the outputs.
*/
`timescale 1ns/100ps
`include "qeo_defs.svh"

module qeo_slew_timer #(
  parameter int W = `QEO_SLEW_W
) (
  // Clock and control
  input  wire logic         core_clk_in,
  input  wire logic         reset_n_in,
  input  wire logic         clk_en_in,
  // Timer
  input  wire logic         load_in,
  input  wire logic [W-1:0] interval_in,
  output      logic         expired_out
);
  import qeo_pkg::*;

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  // Reload on a step, so the next step waits a full interval
  assign cnt_d = load_in ? interval_in :
                 (cnt_q != '0) ? cnt_q - W'(1) : cnt_q;
  assign expired_out = (cnt_q == '0);

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      cnt_q <= '0;
    end else if (clk_en_in) begin
      cnt_q <= cnt_d;
    end
  end

endmodule : qeo_slew_timer

// [verilog/qeo_encoder_out.sv]
/*
  Quadrature A/B and index generator driven by sampled angle, with an
  optional slew-rate limiter that walks the outputs through valid states.
  Assumes samples come from logic on core_clk_in, one valid pulse per
  angle-sample period, and the resolution code and slew interval are
  static configuration levels from the same clock domain.
*/
`timescale 1ns/100ps
`include "qeo_defs.svh"

// Summary of operation
// - A and B have 50% duty over angle, 2^N cycles per revolution.
// - B leads A by a quarter cycle on rising angle, forming a quadrature pair.
// - Index output is high once per revolution at zero angle.
// - States are Q1=00, Q2=01, Q3=11, Q4=10 as (A,B).
// - Only one of A or B changes on any state transition while slew limiting is on.
// - Rising angle steps Q1-Q2-Q3-Q4-Q1; falling steps in reverse.
// - Each state spans 360/(4*2^N) degrees, four states per cycle.
// - Code 3..14 gives N = 14 - code; other codes are not used.
// - A nonzero slew interval enables slew-rate limiting.
// - Skipped states are stepped through one per slew interval plus one cycle until caught up.
// - Without slew, outputs follow each 1 us angle sample directly.
// - After reset show zero, then approach the angle by the shorter way.
module qeo_encoder_out #(
  parameter int SLEW_W = `QEO_SLEW_W
) (
  // Clock, reset, enable
  input  wire logic              core_clk_in,
  input  wire logic              reset_n_in,
  input  wire logic              clk_en_in,
  // Angle samples
  input  wire qeo_pkg::qeo_sample_s sample_in,
  // Configuration
  input  wire logic [3:0]        resolution_code_in,
  input  wire logic [SLEW_W-1:0] slew_interval_in,
  // Encoder outputs
  output      qeo_pkg::qeo_abi_s incremental_output_out,
  output      logic              catching_up_out
);
  import qeo_pkg::*;

  localparam int PW = `QEO_POS_W;

  function automatic qeo_quad_e qeo_quad_of(input logic [1:0] p);
    qeo_quad_e q;
    q = QEO_Q1;
    unique case (p)
      2'h0: q = QEO_Q1;
      2'h1: q = QEO_Q2;
      2'h2: q = QEO_Q3;
      2'h3: q = QEO_Q4;
    endcase
    return q;
  endfunction : qeo_quad_of

  logic [PW-1:0] pos_q;
  logic [PW-1:0] pos_d;
  logic [PW-1:0] tgt_q;
  logic [PW-1:0] tgt_d;
  qeo_abi_s      abi_q;
  qeo_abi_s      abi_d;
  logic          busy_q;
  logic          busy_d;

  // Resolution decode
  wire           code_ok  = (resolution_code_in >= `QEO_CODE_MIN) &&
                            (resolution_code_in <= `QEO_CODE_MAX);
  wire [3:0]     cyc_bits = `QEO_CODE_TOP - resolution_code_in;
  wire [3:0]     shift    = resolution_code_in - `QEO_SHIFT_BASE;
  // Modulus wraps to zero at 8192 states, so the mask still works
  wire [PW-1:0]  mask     = (`QEO_QUAD_UNIT << cyc_bits) - `QEO_POS_STEP;
  wire [PW-1:0]  smp_tgt  = PW'(sample_in.angle >> shift) & mask;

  wire           slew_en  = (slew_interval_in != '0);
  wire           take_smp = sample_in.valid && code_ok;
  wire [PW-1:0]  diff     = (tgt_q - pos_q) & mask;
  wire           lagging  = (diff != '0);
  // Shorter way round; a tie at half a revolution goes down
  wire           go_up    = (diff <= (mask >> 1));
  wire           expired;
  wire           step     = slew_en && code_ok && lagging && expired;
  wire [PW-1:0]  pos_up   = (pos_q + `QEO_POS_STEP) & mask;
  wire [PW-1:0]  pos_dn   = (pos_q - `QEO_POS_STEP) & mask;

  assign tgt_d  = take_smp ? smp_tgt : tgt_q;
  // No slew: jump straight to the new sample
  assign pos_d  = (!slew_en && take_smp) ? smp_tgt :
                  step ? (go_up ? pos_up : pos_dn) : pos_q;
  // Gray map of position gives quarter-cycle B offset
  assign abi_d.a = qeo_quad_of(pos_d[1:0]) inside {QEO_Q3, QEO_Q4};
  assign abi_d.b = qeo_quad_of(pos_d[1:0]) inside {QEO_Q2, QEO_Q3};
  assign abi_d.i = (pos_d == '0);
  assign busy_d  = slew_en && code_ok && (((tgt_d - pos_d) & mask) != '0);

  qeo_slew_timer #(
    .W (SLEW_W)
  ) u_slew_timer (
    .core_clk_in (core_clk_in),
    .reset_n_in  (reset_n_in),
    .clk_en_in   (clk_en_in),
    .load_in     (step),
    .interval_in (slew_interval_in),
    .expired_out (expired)
  );

  // Reset shows the zero angle state with index high
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      pos_q  <= `QEO_POS_RST;
      tgt_q  <= `QEO_POS_RST;
      abi_q  <= '{a: 1'b0, b: 1'b0, i: 1'b1};
      busy_q <= 1'b0;
    end else if (clk_en_in) begin
      pos_q  <= pos_d;
      tgt_q  <= tgt_d;
      abi_q  <= abi_d;
      busy_q <= busy_d;
    end
  end

  assign incremental_output_out = abi_q;
  assign catching_up_out        = busy_q;

  // Checking helpers
  logic [15:0] gap_q;
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      gap_q <= 16'h0000;
    end else if (clk_en_in) begin
      gap_q <= (abi_d != abi_q) ? 16'h0000 :
               (gap_q == 16'hFFFF) ? gap_q : gap_q + 16'h0001;
    end
  end
  wire [1:0] ab_now = {abi_q.a, abi_q.b};

  gray_step_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    slew_en |-> $countones(ab_now ^ $past(ab_now)) <= 1)
    else $error("A and B changed together");

  quad_order_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    (step && clk_en_in) |=> (pos_q == $past(pos_up)) || (pos_q == $past(pos_dn)))
    else $error("Slew step was not to a neighbouring state");

  duty_quad_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    ##1 (abi_q.a == pos_q[1]) && (abi_q.b == (pos_q[1] ^ pos_q[0])))
    else $error("Outputs do not match quadrature position");

  index_zero_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    abi_q.i |-> (ab_now == 2'h0) && (pos_q == '0))
    else $error("Index high away from zero angle");

  slew_space_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    (slew_en && clk_en_in && abi_d != abi_q && $stable(slew_interval_in)
     && !$rose(slew_en)) |-> gap_q >= 16'(slew_interval_in) - 16'h0001)
    else $error("Output changes closer than slew interval");

  catch_up_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    (step && clk_en_in) |=> (pos_q != $past(pos_q)) && (tgt_q == $past(tgt_d)))
    else $error("Pending slew step did not move outputs");

  follow_sample_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    (!slew_en && take_smp && clk_en_in) |=> pos_q == $past(smp_tgt))
    else $error("Unlimited output did not follow sample");

  reset_zero_a: assert property (@(posedge core_clk_in)
    !reset_n_in |=> (abi_q == 3'h1) && (pos_q == '0) && !busy_q)
    else $error("Reset does not show zero angle");

  shortest_way_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    (step && clk_en_in && diff <= (mask >> 1)) |=> pos_q == $past(pos_up))
    else $error("Catch-up went the longer way");

  bad_code_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    (!code_ok && $stable(resolution_code_in)) |=> $stable(pos_q))
    else $error("Position moved under an unused code");

  // Flag must track the lag exactly while the setup stands still
  busy_flag_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    ($stable(slew_interval_in) && $stable(resolution_code_in))
      |-> busy_q == (slew_en && code_ok && lagging))
    else $error("Catching-up flag disagrees with the lag");

  target_load_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    (take_smp && clk_en_in) |=> tgt_q == $past(smp_tgt))
    else $error("Accepted sample did not become the target");

  // Limited outputs may only move when the timer has run out
  step_expiry_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    (clk_en_in && slew_en && (abi_d != abi_q) && $stable(resolution_code_in)
     && $stable(slew_interval_in)) |-> expired)
    else $error("Output moved before the slew timer expired");

  // A tie at exactly half a revolution resolves downwards
  tie_down_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    (step && clk_en_in && diff == ((mask >> 1) + `QEO_POS_STEP)) |=> pos_q == $past(pos_dn))
    else $error("Half-revolution catch-up did not go down");

  index_set_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    (pos_q == '0) |-> abi_q.i)
    else $error("Index low at zero angle");

  slew_walk_c: cover property (@(posedge core_clk_in) disable iff (!reset_n_in)
    step ##1 busy_q ##[1:300] (step && !go_up));
  index_pass_c: cover property (@(posedge core_clk_in) disable iff (!reset_n_in)
    !abi_q.i ##1 abi_q.i);
  jump_c: cover property (@(posedge core_clk_in) disable iff (!reset_n_in)
    (!slew_en && take_smp && (diff > `QEO_POS_STEP)));
  settle_c: cover property (@(posedge core_clk_in) disable iff (!reset_n_in)
    $fell(busy_q));
  up_walk_c: cover property (@(posedge core_clk_in) disable iff (!reset_n_in)
    (step && go_up));

endmodule : qeo_encoder_out

// [verification/qeo_host_decoder.sv]
/*
  Host-side quadrature decoder and position counter model.
  Assumes A/B levels come from the block and the same resolution code.
*/
`timescale 1ns/100ps

module qeo_host_decoder (
  // Clock and reset
  input  wire logic              core_clk_in,
  input  wire logic              reset_n_in,
  // Encoder lines and setup
  input  wire qeo_pkg::qeo_abi_s abi_in,
  input  wire logic [3:0]        code_in,
  // Decoded position
  output      logic [15:0]       pos_out,
  output      logic              bad_out
);
  import qeo_pkg::*;

  logic [1:0]  idx_q;
  logic [1:0]  idx_d;
  logic [15:0] mask;

  // State index from the gray pair
  assign idx_d = {abi_in.a, abi_in.a ^ abi_in.b};
  assign mask  = (16'h0004 << (4'hE - code_in)) - 16'h0001;

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      idx_q   <= 2'h0;
      pos_out <= 16'h0000;
      bad_out <= 1'b0;
    end else if (idx_d != idx_q) begin
      idx_q <= idx_d;
      if (idx_d == idx_q + 2'h1) begin
        pos_out <= (pos_out + 16'h0001) & mask;
      end else if (idx_d == idx_q - 2'h1) begin
        pos_out <= (pos_out - 16'h0001) & mask;
      end else begin
        // Skipped state: a real counter would lose position
        bad_out <= 1'b1;
      end
    end
  end
endmodule : qeo_host_decoder

// [verification/quadrature_encoder_output_test.sv]
/*
  Self-checking bench for the quadrature encoder output block.
  Assumes qeo_pkg, the design and the host decoder model are compiled first.
*/
`timescale 1ns/100ps

module quadrature_encoder_output_test;
  import qeo_pkg::*;

  logic              core_clk_in;
  logic              reset_n_in;
  logic              clk_en_in;
  qeo_sample_s       sample_in;
  logic [3:0]        resolution_code_in;
  logic [7:0]        slew_interval_in;
  qeo_abi_s          incremental_output_out;
  logic              catching_up_out;
  logic [2:0]        abi_w;
  logic [15:0]       pos_w;
  logic              bad_w;
  int                err_count;
  int                total_checks;

  assign abi_w = incremental_output_out;

  qeo_encoder_out i_dut (
    .core_clk_in            (core_clk_in),
    .reset_n_in             (reset_n_in),
    .clk_en_in              (clk_en_in),
    .sample_in              (sample_in),
    .resolution_code_in     (resolution_code_in),
    .slew_interval_in       (slew_interval_in),
    .incremental_output_out (incremental_output_out),
    .catching_up_out        (catching_up_out)
  );

  qeo_host_decoder i_host (
    .core_clk_in (core_clk_in),
    .reset_n_in  (reset_n_in),
    .abi_in      (incremental_output_out),
    .code_in     (resolution_code_in),
    .pos_out     (pos_w),
    .bad_out     (bad_w)
  );

  always #5 core_clk_in = ~core_clk_in;

  task test_done;
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done

  task chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask : chk

  // Expected {A,B,I} for state index p
  function automatic logic [2:0] exp_abi(input int p);
    return {p[1], p[1] ^ p[0], p == 0};
  endfunction : exp_abi

  task send(input int ang);
    @(posedge core_clk_in);
    sample_in <= {1'b1, ang[13:0]};
    @(posedge core_clk_in);
    sample_in.valid <= 1'b0;
  endtask : send

  task wait_abi(input logic [2:0] e, input int lim, output int n);
    for (n = 1; n <= lim; n++) begin
      @(posedge core_clk_in);
      #1;
      if (abi_w === e) return;
    end
    chk({13'h0000, abi_w}, {13'h0000, e});
    err_count++;
    test_done();
  endtask : wait_abi

  task step(input int p, input int code);
    int n;
    send(p << (code - 2));
    wait_abi(exp_abi(p), 3, n);
    @(posedge core_clk_in);
    #1;
    chk(pos_w, p[15:0]);
  endtask : step

  task t_reset;
    chk({abi_w, catching_up_out}, 16'h0002);
  endtask : t_reset

  // Full revolution up past zero, then down through zero
  task t_sweep(input int code);
    int m;
    m = 4 << (14 - code);
    resolution_code_in <= code[3:0];
    for (int k = 1; k <= m + 1; k++) step(k % m, code);
    step(0, code);
    step(m - 1, code);
    step(m - 2, code);
  endtask : t_sweep

  // Half-revolution jump at slew 2: two steps, three cycles apart
  task t_slew;
    int n;
    slew_interval_in <= 8'h02;
    send(0);
    @(posedge core_clk_in);
    #1;
    chk({15'h0000, catching_up_out}, 16'h0001);
    wait_abi(exp_abi(0), 8, n);
    chk(16'(n), 16'h0003);
    // Host counter takes the last edge one clock later
    @(posedge core_clk_in);
    #1;
    chk({12'h000, bad_w, catching_up_out, pos_w[1:0]}, 16'h0000);
    slew_interval_in <= 8'h00;
  endtask : t_slew

  // Frozen outputs: clock enable low, then reserved code
  task t_refuse;
    logic [2:0] held;
    held = abi_w;
    for (int r = 0; r < 2; r++) begin
      clk_en_in <= (r != 0);
      resolution_code_in <= (r == 0) ? 4'hD : 4'hF;
      send(16'h0800);
      repeat (4) @(posedge core_clk_in);
      #1;
      chk({13'h0000, abi_w}, {13'h0000, held});
    end
    clk_en_in <= 1'b1;
    resolution_code_in <= 4'hD;
  endtask : t_refuse

  initial begin
    core_clk_in = 1'b0;
    reset_n_in = 1'b0;
    clk_en_in = 1'b1;
    sample_in = '0;
    resolution_code_in = 4'hE;
    slew_interval_in = 8'h00;
    err_count = 0;
    total_checks = 0;
    repeat (5) @(posedge core_clk_in);
    reset_n_in <= 1'b1;
    @(posedge core_clk_in);
    #1;
    t_reset();
    t_sweep(14);
    t_slew();
    t_sweep(13);
    t_refuse();
    test_done();
  end
endmodule : quadrature_encoder_output_test
